//--- src/fstc_flash_sink_timing_control.sv
// Flash sink timing control: register file, flash pulse sequencer and sink drive.
// Assumes the trigger and torch pins are synchronous to clock and an APB master drives apbReq.
`timescale 1ns/100ps

// Behaviour
// R1: Flash current of the paralleled sinks is gated by the trigger pin per mode.
// R2: Mode one starts on trigger rise and lasts the fixed duration only.
// R3: Mode two stops on trigger fall or when the programmed limit expires.
// R4: Mode three runs from trigger rise to trigger fall without limit.
// R5: Select field bits 1:0 picks mode: 00 one, 01 two, 1x three; resets 01.
// R6: Power register bits 1 to 3 switch each sink on; reset off.
// R7: Torch soft bit 4 applies torch level when set; ignored under pin control.
// R8: Torch source bit 5 chooses soft bit when 0, torch pin when 1.
// R9: Flash soft bit 6 applies flash level when set; ignored under pin control.
// R10: Flash source bit 7 chooses trigger pin when 0, flash soft bit when 1.
// R11: Fixed duration code bits 2:0, reset 001, gives 100 ms to 800 ms.
// R12: A millisecond counter measures limits and restarts on each new pulse.
module fstc_flash_sink_timing_control
#(
	parameter int CYCLES_PER_MS = fstc_pkg::CYCLES_PER_MS
)
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst,
	// APB register bus
	input  wire fstc_pkg::fstc_apb_req_t apbReq,
	output      fstc_pkg::fstc_apb_rsp_t apbRsp,
	// Camera module pins
	input  wire logic                    flashTriggerPin,
	input  wire logic                    torchPin,
	// Sink drive
	output      logic [2:0]              sinkOn,
	output      logic [7:0]              sinkLevel,
	output      logic                    flashActive
);
	localparam int MW = fstc_pkg::MS_WIDTH;

	logic [3:0]                  powerCtrl;
	logic [1:0]                  modeSel;
	logic                        torchSoftOn;
	logic                        torchPinSel;
	logic                        flashSoftOn;
	logic                        flashSoftSel;
	logic [7:0]                  torchLevel;
	logic [7:0]                  flashLevel;
	logic [2:0]                  fixedCode;
	logic [2:0]                  limitCode;
	logic [3:0]                  regIdx;
	logic                        regWrite;
	logic [7:0]                  regWdata;
	logic [7:0]                  regRdata;
	logic                        regHit;
	logic                        triggerPrev;
	logic                        triggerRise;
	logic                        pulseStart;
	logic [MW-1:0]               msCount;
	logic [MW-1:0]               fixedMs;
	logic [MW-1:0]               limitMs;
	logic                        flashCur;
	logic                        torchCur;
	fstc_pkg::fstc_flash_state_t state;
	fstc_pkg::fstc_flash_state_t next_state;
	logic [2:0]                  next_sinkOn;
	logic [7:0]                  next_sinkLevel;

	fstc_apb_slave u_apb
	(
		.clock    (clock),
		.rst      (rst),
		.apbReq   (apbReq),
		.apbRsp   (apbRsp),
		.regIdx   (regIdx),
		.regWrite (regWrite),
		.regWdata (regWdata),
		.regRdata (regRdata),
		.regHit   (regHit)
	);

	fstc_ms_timer
	#(
		.CYCLES_PER_MS (CYCLES_PER_MS),
		.MS_WIDTH      (MW)
	)
	u_timer
	(
		.clock   (clock),
		.rst     (rst),
		.restart (pulseStart),
		.msCount (msCount)
	);

	// Power control register.
	always_ff @(posedge clock)
	begin
		if (rst)
			powerCtrl <= fstc_pkg::RST_POWER; // R6
		else if (regWrite && (regIdx == fstc_pkg::IDX_POWER))
			powerCtrl <= regWdata[3:0]; // R6
	end

	// Sink control register.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			modeSel      <= fstc_pkg::RST_MODE_SEL; // R5
			torchSoftOn  <= 1'b0;
			torchPinSel  <= 1'b0;
			flashSoftOn  <= 1'b0;
			flashSoftSel <= 1'b0;
		end
		else if (regWrite && (regIdx == fstc_pkg::IDX_CONTROL))
		begin
			modeSel      <= regWdata[1:0]; // R5
			torchSoftOn  <= regWdata[fstc_pkg::POS_TORCH_ON];
			torchPinSel  <= regWdata[fstc_pkg::POS_TORCH_PIN];
			flashSoftOn  <= regWdata[fstc_pkg::POS_FLASH_ON];
			flashSoftSel <= regWdata[fstc_pkg::POS_FLASH_SOFT];
		end
	end

	// Level and duration registers.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			torchLevel <= fstc_pkg::RST_LEVEL;
			flashLevel <= fstc_pkg::RST_LEVEL;
			fixedCode  <= fstc_pkg::RST_DURATION; // R11
			limitCode  <= fstc_pkg::RST_DURATION;
		end
		else if (regWrite)
		begin
			if (regIdx == fstc_pkg::IDX_TORCH)
				torchLevel <= regWdata;
			if (regIdx == fstc_pkg::IDX_FLASH)
				flashLevel <= regWdata;
			if (regIdx == fstc_pkg::IDX_FIXED)
				fixedCode <= regWdata[2:0]; // R11
			if (regIdx == fstc_pkg::IDX_LIMIT)
				limitCode <= regWdata[2:0];
		end
	end

	// Read mux; reserved bits read as zero and the status word is read-only.
	always_comb
	begin
		regHit   = 1'b1;
		regRdata = 8'h00;
		unique case (regIdx)
			fstc_pkg::IDX_POWER:   regRdata = {4'h0, powerCtrl};
			fstc_pkg::IDX_TORCH:   regRdata = torchLevel;
			fstc_pkg::IDX_FLASH:   regRdata = flashLevel;
			fstc_pkg::IDX_CONTROL: regRdata = {flashSoftSel, flashSoftOn, torchPinSel,
				torchSoftOn, 2'h0, modeSel};
			fstc_pkg::IDX_FIXED:   regRdata = {5'h00, fixedCode};
			fstc_pkg::IDX_LIMIT:   regRdata = {5'h00, limitCode};
			fstc_pkg::IDX_STATUS:  regRdata = {1'b0, flashActive, flashTriggerPin,
				torchPin, 1'b0, sinkOn};
			default:               regHit   = 1'b0;
		endcase
	end

	// Trigger edge detection; the pin is already synchronous to clock.
	always_ff @(posedge clock)
	begin
		if (rst)
			triggerPrev <= 1'b0;
		else
			triggerPrev <= flashTriggerPin;
	end

	assign triggerRise = flashTriggerPin && !triggerPrev;
	// Each code step is one hundred milliseconds, code zero being the first step.
	assign fixedMs     = (MW'(fixedCode) + MW'(1)) * MW'(fstc_pkg::STEP_MS); // R11
	assign limitMs     = (MW'(limitCode) + MW'(1)) * MW'(fstc_pkg::STEP_MS); // R3
	assign pulseStart  = (state == fstc_pkg::FS_IDLE) && !flashSoftSel && triggerRise; // R12

	// Flash pulse sequencer. Handing flash control to software aborts a running pulse.
	always_comb
	begin
		next_state = state;
		unique case (state)
			fstc_pkg::FS_IDLE:
			begin
				if (pulseStart) // R1
				begin
					if (modeSel == fstc_pkg::MODE_FIXED)
						next_state = fstc_pkg::FS_FIXED; // R2
					else if (modeSel == fstc_pkg::MODE_LIMIT)
						next_state = fstc_pkg::FS_LIMIT; // R3
					else
						next_state = fstc_pkg::FS_OPEN; // R4
				end
			end
			fstc_pkg::FS_FIXED:
			begin
				if (flashSoftSel || (msCount >= fixedMs)) // R2
					next_state = fstc_pkg::FS_IDLE;
			end
			fstc_pkg::FS_LIMIT:
			begin
				if (flashSoftSel || !flashTriggerPin || (msCount >= limitMs)) // R3
					next_state = fstc_pkg::FS_IDLE;
			end
			fstc_pkg::FS_OPEN:
			begin
				if (flashSoftSel || !flashTriggerPin) // R4
					next_state = fstc_pkg::FS_IDLE;
			end
			default: next_state = fstc_pkg::FS_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			state <= fstc_pkg::FS_IDLE;
		else
			state <= next_state;
	end

	// Source selection for flash and torch current.
	assign flashCur = flashSoftSel ? flashSoftOn : (state != fstc_pkg::FS_IDLE); // R9 R10
	assign torchCur = torchPinSel ? torchPin : torchSoftOn; // R7 R8

	// Flash takes precedence over torch; a disabled sink carries no current.
	always_comb
	begin
		next_sinkLevel = 8'h00;
		if (flashCur)
			next_sinkLevel = flashLevel; // R9
		else if (torchCur)
			next_sinkLevel = torchLevel; // R7
		next_sinkOn = powerCtrl[fstc_pkg::POS_SINK_A +: 3] & {3{flashCur || torchCur}}; // R6
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sinkOn      <= 3'h0;
			sinkLevel   <= 8'h00;
			flashActive <= 1'b0;
		end
		else
		begin
			sinkOn      <= next_sinkOn;
			sinkLevel   <= next_sinkLevel;
			flashActive <= flashCur;
		end
	end

	mode_select_a: assert property ( // R5
		@(posedge clock) disable iff (rst)
		(pulseStart && modeSel[1]) |=> (state == fstc_pkg::FS_OPEN))
		else $error("mode three not entered for select 1x");

	fixed_start_a: assert property ( // R2
		@(posedge clock) disable iff (rst)
		(pulseStart && (modeSel == fstc_pkg::MODE_FIXED)) |=> (state == fstc_pkg::FS_FIXED))
		else $error("mode one pulse not started");

	fixed_hold_a: assert property ( // R2
		@(posedge clock) disable iff (rst)
		((state == fstc_pkg::FS_FIXED) && !flashSoftSel && (msCount < fixedMs))
		|=> (state == fstc_pkg::FS_FIXED))
		else $error("mode one pulse ended before its duration");

	limit_stop_a: assert property ( // R3
		@(posedge clock) disable iff (rst)
		((state == fstc_pkg::FS_LIMIT) && ((msCount >= limitMs) || !flashTriggerPin))
		|=> (state == fstc_pkg::FS_IDLE) ##1 !flashActive || flashSoftSel)
		else $error("mode two pulse not stopped");

	open_run_a: assert property ( // R4
		@(posedge clock) disable iff (rst)
		((state == fstc_pkg::FS_OPEN) && flashTriggerPin && !flashSoftSel)
		|=> (state == fstc_pkg::FS_OPEN))
		else $error("mode three pulse ended while trigger high");

	sink_gate_a: assert property ( // R6
		@(posedge clock) disable iff (rst)
		!powerCtrl[fstc_pkg::POS_SINK_A] |=> !sinkOn[0])
		else $error("disabled sink switched on");

	torch_pin_a: assert property ( // R8
		@(posedge clock) disable iff (rst)
		(torchPinSel && torchPin && !flashCur) |=> (sinkLevel == $past(torchLevel)))
		else $error("torch pin level not applied");

	torch_ignore_a: assert property ( // R7
		@(posedge clock) disable iff (rst)
		(torchPinSel && !torchPin && !flashCur) |=> (sinkOn == 3'h0))
		else $error("torch soft bit acted under pin control");

	flash_soft_a: assert property ( // R9
		@(posedge clock) disable iff (rst)
		(!flashSoftSel && (state == fstc_pkg::FS_IDLE) && !torchCur)
		|=> (sinkOn == 3'h0))
		else $error("flash soft bit acted under pin control");

	flash_source_a: assert property ( // R10
		@(posedge clock) disable iff (rst)
		(flashSoftSel && flashSoftOn) |=> (flashActive && (sinkLevel == $past(flashLevel))))
		else $error("flash soft control not applied");

	timer_restart_a: assert property ( // R12
		@(posedge clock) disable iff (rst)
		pulseStart |=> (msCount == '0) ##1 (msCount <= MW'(1)))
		else $error("millisecond counter not restarted");

	fixed_reset_a: assert property ( // R11
		@(posedge clock)
		($past(rst) && !rst) |-> (fixedCode == fstc_pkg::RST_DURATION)
			&& (modeSel == fstc_pkg::RST_MODE_SEL))
		else $error("duration or mode reset value wrong");
endmodule

//--- inc/fstc_pkg.sv
// Constants, register map and carrier types of the flash sink timing control.
// Assumes a 250 MHz clock and an APB master with 32-bit data.
package fstc_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_POWER   = 4'h0;
	localparam logic [3:0] IDX_TORCH   = 4'h1;
	localparam logic [3:0] IDX_FLASH   = 4'h2;
	localparam logic [3:0] IDX_CONTROL = 4'h3;
	localparam logic [3:0] IDX_FIXED   = 4'h4;
	localparam logic [3:0] IDX_LIMIT   = 4'h5;
	localparam logic [3:0] IDX_STATUS  = 4'h8;

	// Field positions.
	localparam int POS_PUMP_POWER  = 0;
	localparam int POS_SINK_A      = 1;
	localparam int POS_TORCH_ON    = 4;
	localparam int POS_TORCH_PIN   = 5;
	localparam int POS_FLASH_ON    = 6;
	localparam int POS_FLASH_SOFT  = 7;

	// Values after reset.
	localparam logic [3:0] RST_POWER     = 4'h0;
	localparam logic [1:0] RST_MODE_SEL  = 2'h1;
	localparam logic [7:0] RST_LEVEL     = 8'h00;
	localparam logic [2:0] RST_DURATION  = 3'h1;

	// Duration modes of the timing select field.
	localparam logic [1:0] MODE_FIXED = 2'h0;
	localparam logic [1:0] MODE_LIMIT = 2'h1;

	// Timing.
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int MS_NS           = 1000000;
	localparam int CYCLES_PER_MS   = MS_NS / CLOCK_PERIOD_NS;
	localparam int STEP_MS         = 100;
	localparam int MS_WIDTH        = 10;

	typedef enum logic [3:0] {
		FS_IDLE  = 4'h1,
		FS_FIXED = 4'h2,
		FS_LIMIT = 4'h4,
		FS_OPEN  = 4'h8
	} fstc_flash_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fstc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} fstc_apb_rsp_t;

endpackage

//--- src/fstc_apb_slave.sv
// APB slave front end: decodes word addresses and registers the answer.
// Assumes the register file gives read data and a hit flag for regIdx combinationally.
`timescale 1ns/100ps
module fstc_apb_slave
(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst,
	// APB
	input  wire fstc_pkg::fstc_apb_req_t apbReq,
	output      fstc_pkg::fstc_apb_rsp_t apbRsp,
	// Register file side
	output      logic [3:0]             regIdx,
	output      logic                   regWrite,
	output      logic [7:0]             regWdata,
	input  wire logic [7:0]             regRdata,
	input  wire logic                   regHit
);
	logic aligned;

	// Only aligned words inside the low sixty-four bytes can hit a register.
	assign aligned  = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[11:6] == 6'h00);
	assign regIdx   = apbReq.paddr[5:2];
	assign regWdata = apbReq.pwdata[7:0];
	// A write lands on the edge where the master sees pready high.
	assign regWrite = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready
		&& aligned && regHit;

	// One wait state: pready rises in the second access cycle and lasts one cycle.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			apbRsp <= '0;
		end
		else
		begin
			apbRsp.pready  <= apbReq.psel && apbReq.penable && !apbRsp.pready;
			apbRsp.pslverr <= apbReq.psel && apbReq.penable && !apbRsp.pready
				&& !(aligned && regHit);
			apbRsp.prdata  <= (aligned && regHit && !apbReq.pwrite)
				? {24'h000000, regRdata} : 32'h00000000;
		end
	end
endmodule

//--- src/fstc_ms_timer.sv
// Millisecond counter that restarts from zero and saturates at its top value.
// Assumes restart is a one-cycle pulse from the flash sequencer.
`timescale 1ns/100ps
module fstc_ms_timer
#(
	parameter int CYCLES_PER_MS = fstc_pkg::CYCLES_PER_MS,
	parameter int MS_WIDTH      = fstc_pkg::MS_WIDTH
)
(
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// Control and count
	input  wire logic                restart,
	output      logic [MS_WIDTH-1:0] msCount
);
	localparam int PW = $clog2(CYCLES_PER_MS + 1);

	logic [PW-1:0] prescale;
	logic          msTick;

	assign msTick = (prescale == PW'(CYCLES_PER_MS - 1));

	always_ff @(posedge clock)
	begin
		if (rst || restart || msTick)
			prescale <= '0;
		else
			prescale <= prescale + PW'(1);
	end

	// Saturation keeps an unlimited pulse from wrapping into a false limit.
	always_ff @(posedge clock)
	begin
		if (rst || restart)
			msCount <= '0;
		else if (msTick && (msCount != {MS_WIDTH{1'b1}}))
			msCount <= msCount + MS_WIDTH'(1);
	end
endmodule

//--- tb/fstc_camera_model.sv
// Camera module model driving the flash trigger and torch request pins.
// Assumes the bench requests a trigger pulse of fireLen cycles with a one-cycle fire strobe.
`timescale 1ns/100ps
module fstc_camera_model
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Requests from the bench
	input  wire logic        fire,
	input  wire logic [15:0] fireLen,
	input  wire logic        torchReq,
	// Pins to the block
	output      logic        flashTriggerPin,
	output      logic        torchPin
);
	logic [15:0] left;

	// Pins change only just after a rising edge, as a synchronous camera would drive them.
	always_ff @(posedge clock)
		if (rst)
			left <= 16'h0000;
		else if (fire)
			left <= fireLen;
		else if (left != 16'h0000)
			left <= left - 16'h0001;

	assign flashTriggerPin = (left != 16'h0000);

	always_ff @(posedge clock)
		torchPin <= rst ? 1'b0 : torchReq;
endmodule

//--- tb/fstc_flash_sink_timing_control_test.sv
// Self-checking bench for the flash sink timing control.
// Assumes one wait state APB answers and a shortened millisecond of ten cycles.
`timescale 1ns/100ps
module fstc_flash_sink_timing_control_test;
	localparam int MS = 10;
	logic                    clock = 1'b0;
	logic                    rst = 1'b1;
	fstc_pkg::fstc_apb_req_t req = '0;
	fstc_pkg::fstc_apb_rsp_t apbRsp;
	logic                    fire = 1'b0;
	logic [15:0]             fireLen = 16'h0000;
	logic                    torchReq = 1'b0;
	logic                    flashTriggerPin;
	logic                    torchPin;
	logic [2:0]              sinkOn;
	logic [7:0]              sinkLevel;
	logic                    flashActive;
	int                      nMismatch = 0;
	int                      nTests = 0;

	always #2 clock = ~clock;

	fstc_flash_sink_timing_control #(.CYCLES_PER_MS(MS)) fstc_flash_sink_timing_control_i (
		.clock(clock), .rst(rst), .apbReq(req), .apbRsp(apbRsp),
		.flashTriggerPin(flashTriggerPin), .torchPin(torchPin),
		.sinkOn(sinkOn), .sinkLevel(sinkLevel), .flashActive(flashActive));

	fstc_camera_model fstc_camera_model_i (
		.clock(clock), .rst(rst), .fire(fire), .fireLen(fireLen), .torchReq(torchReq),
		.flashTriggerPin(flashTriggerPin), .torchPin(torchPin));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tallyAndFinish();
		$display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// The request is held until pready is seen high at a rising edge, then released.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clock);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (apbRsp.pready !== 1'b1 && n < 50);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 50)
			check(32'h0, 32'h1);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        err;
		apb(a, 1'b1, {24'h000000, d}, rd, err);
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [7:0] exp, input logic expErr);
		logic [31:0] rd;
		logic        err;
		apb(a, 1'b0, 32'h0, rd, err);
		check(rd, {24'h000000, exp});
		check({31'h0, err}, {31'h0, expErr});
	endtask

	// Fires a trigger of len cycles and measures how long flash current stands.
	task automatic pulse(input logic [15:0] len, input int lo, input int hi);
		int n;
		@(posedge clock);
		fire <= 1'b1;
		fireLen <= len;
		@(posedge clock);
		fire <= 1'b0;
		n = 0;
		while (flashActive !== 1'b1 && n < 20)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		check({29'h0, sinkOn}, 32'h7);
		check({24'h0, sinkLevel}, 32'h5a);
		n = 0;
		while (flashActive === 1'b1 && n < 20000)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		nTests++;
		if (n < lo || n > hi)
		begin
			nMismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, n, lo);
		end
		// A trigger that outlives the pulse must fall first, or the next pulse has no rising edge.
		while (flashTriggerPin === 1'b1)
			@(posedge clock);
		repeat (20) @(posedge clock);
	endtask

	task automatic scenarioReset();
		rdChk(12'h000, 8'h00, 1'b0);
		rdChk(12'h00c, 8'h01, 1'b0);
		rdChk(12'h010, 8'h01, 1'b0);
		rdChk(12'h014, 8'h01, 1'b0);
		rdChk(12'h018, 8'h00, 1'b1);
		rdChk(12'h002, 8'h00, 1'b1);
		rdChk(12'h004, 8'h00, 1'b0);
		rdChk(12'h008, 8'h00, 1'b0);
		rdChk(12'h020, 8'h00, 1'b0);
	endtask

	task automatic scenarioModes();
		wr(12'h000, 8'h0e);
		wr(12'h008, 8'h5a);
		wr(12'h010, 8'h00);
		wr(12'h014, 8'h00);
		wr(12'h00c, 8'h00);
		pulse(16'd50, 100 * MS - 10, 100 * MS + 15);
		wr(12'h010, 8'h01);
		pulse(16'd50, 200 * MS - 10, 200 * MS + 15);
		pulse(16'd3000, 200 * MS - 10, 200 * MS + 15);
		wr(12'h00c, 8'h01);
		pulse(16'd300, 298, 302);
		pulse(16'd3000, 100 * MS - 10, 100 * MS + 15);
		wr(12'h00c, 8'h02);
		pulse(16'd2500, 2498, 2502);
		wr(12'h00c, 8'h03);
		pulse(16'd1200, 1198, 1202);
	endtask

	task automatic scenarioSoft();
		wr(12'h00c, 8'h40);
		check({24'h0, sinkLevel}, 32'h0);
		wr(12'h00c, 8'h80);
		@(posedge clock);
		fire <= 1'b1;
		fireLen <= 16'd40;
		@(posedge clock);
		fire <= 1'b0;
		repeat (10) @(posedge clock);
		#1;
		check({31'h0, flashActive}, 32'h0);
		wr(12'h00c, 8'hc0);
		check({24'h0, sinkLevel}, 32'h5a);
		check({29'h0, sinkOn}, 32'h7);
		wr(12'h00c, 8'h01);
		wr(12'h000, 8'h04);
		wr(12'h004, 8'h33);
		wr(12'h00c, 8'h11);
		check({24'h0, sinkLevel}, 32'h33);
		check({29'h0, sinkOn}, 32'h2);
		wr(12'h00c, 8'h31);
		check({24'h0, sinkLevel}, 32'h0);
		@(posedge clock);
		torchReq <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		check({24'h0, sinkLevel}, 32'h33);
		rdChk(12'h020, 8'h12, 1'b0);
		wr(12'h00c, 8'h01);
		check({24'h0, sinkLevel}, 32'h0);
		check({29'h0, sinkOn}, 32'h0);
	endtask

	initial
	begin
		#(4 * 40000);
		nMismatch++;
		tallyAndFinish();
	end

	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		scenarioReset();
		scenarioModes();
		scenarioSoft();
		tallyAndFinish();
	end
endmodule
